/* File: verilog/rt_mode_dma.sv */
// Functional notes
// - Revision B flags extra receive data words; revision A does not check.
// - Revision A status starts 4.25 to 5.75 after command parity midbit.
// - Revision B status starts 9.25 to 10 after command parity midbit.
// - Revision B: code 0 and reserved codes set message error, no action.
// - Codes 1, 2, 3, 8 send status and store command only.
// - Codes 4 to 7 act internally even when externally illegalized.
// - Codes 16,17,19,20,21 store command and move one data word.
// - Code 18 updates held last command instead of storing it.
// - Selected shutdown holds a channel off until override arrives.
// - Terminal address read continuously from static pins.
// - Bad address parity ignores commands and sets status bit 12.
// - Transmit requests DMA when buffer empties; late grant is overrun.
// - Transmit keeps requesting per word until count done or error.
// - Receive requests DMA per validated word; late grant is overrun.
// - On grant with permit, drive address, then address valid.
// - Write strobe for receive, read strobe for transmit ends access.
// - Pending ungranted request drops on command, error or stop write.
// - Protocol select 1 gives revision A, 0 gives revision B.
// - External illegal input sets message error; auto actions still run.
//
// The strobed register port and the register offsets were left to the implementer.
module rt_mode_dma #(
  parameter int LAT_CYC = 0
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            protocol_rev_select,
  input  wire logic            illegal_command_in,
  input  wire logic [4:0]      term_addr_pins,
  input  wire logic            term_addr_parity_in,
  input  wire logic            addr_parity_check_en,
  input  wire logic            term_fault_in,
  input  wire logic            cmd_valid,
  input  wire rt_pkg::cmd_s    cmd_word,
  input  wire logic            cmd_chan,
  input  wire logic            rx_word_valid,
  input  wire logic [15:0]     rx_word,
  input  wire logic            tx_word_done,
  input  wire logic            dma_gnt,
  input  wire logic            dma_permit,
  input  wire logic [15:0]     mem_rdata,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [15:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [15:0]          reg_rdata,
  output logic                 status_start,
  output rt_pkg::status_s      status_word,
  output logic                 tx_word_valid,
  output logic [15:0]          tx_word,
  output logic [1:0]           chan_tx_enable,
  output logic                 addr_parity_fault_flag,
  output logic                 dma_req,
  output logic [15:0]          mem_addr,
  output logic                 mem_addr_oe,
  output logic [15:0]          mem_wdata,
  output logic                 mem_data_oe,
  output logic                 addr_valid_strobe,
  output logic                 mem_read_strobe,
  output logic                 mem_write_strobe
);
  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [10:0] pin_meta, pin_sync;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= 11'h000;
      pin_sync <= 11'h000;
    end else begin
      pin_meta <= {dma_permit, dma_gnt, addr_parity_check_en,
                   term_addr_parity_in, term_addr_pins,
                   illegal_command_in, protocol_rev_select};
      pin_sync <= pin_meta;
    end
  end

  logic       rev_a, ill_s, par_en, par_in, gnt_s, permit_s, parity_bad;
  logic [4:0] my_addr;
  assign rev_a    = pin_sync[0];
  assign ill_s    = pin_sync[1];
  assign my_addr  = pin_sync[6:2];
  assign par_in   = pin_sync[7];
  assign par_en   = pin_sync[8];
  assign gnt_s    = pin_sync[9];
  assign permit_s = pin_sync[10];
  assign parity_bad = par_en && !(^{my_addr, par_in});

  //////////////////////////////////////////////////////////////////////////
  // Submodules
  logic             dma_busy, dma_done, fire, abort;
  logic [15:0]      dma_rd_word;
  logic             job_valid, timer_start;
  rt_pkg::dma_job_s job;

  resp_timer #(.LAT_CYC(LAT_CYC)) u_timer (
    .clk   (clk),
    .rstn  (rstn),
    .start (timer_start),
    .rev_a (rev_a),
    .fire  (fire)
  );

  dma_seq u_dma (
    .clk               (clk),
    .rstn              (rstn),
    .job_valid         (job_valid),
    .job               (job),
    .abort             (abort),
    .gnt               (gnt_s),
    .permit            (permit_s),
    .mem_rdata         (mem_rdata),
    .busy              (dma_busy),
    .done              (dma_done),
    .rd_word           (dma_rd_word),
    .dma_req           (dma_req),
    .mem_addr          (mem_addr),
    .mem_addr_oe       (mem_addr_oe),
    .mem_wdata         (mem_wdata),
    .mem_data_oe       (mem_data_oe),
    .addr_valid_strobe (addr_valid_strobe),
    .mem_read_strobe   (mem_read_strobe),
    .mem_write_strobe  (mem_write_strobe)
  );

  //////////////////////////////////////////////////////////////////////////
  // Message sequencer and registers
  typedef enum logic [1:0] {M_IDLE, M_RX, M_RESP, M_TX} msg_e;

  msg_e         st, next_st;
  rt_pkg::cmd_s cmd, next_cmd;
  logic [5:0]   total, next_total, count, next_count;
  logic         tx_dir, next_tx_dir, msg_err, next_msg_err;
  logic         buf_full, next_buf_full;
  logic [15:0]  next_tx_word, last_cmd, next_last_cmd;
  logic [1:0]   shut, next_shut, sel_off, next_sel_off;
  logic         inhibit, next_inhibit, test_act, next_test_act;
  logic         ovr_flag, next_ovr_flag, err_flag, next_err_flag;
  logic         par_flag, next_par_flag;
  logic [15:0]  data_base, next_data_base, cmd_ptr, next_cmd_ptr;
  logic [15:0]  mc_ptr, next_mc_ptr, next_reg_rdata, operational_status_reg;
  logic         next_job_valid, next_status_start, next_timer_start;
  rt_pkg::dma_job_s next_job;
  rt_pkg::status_s  next_status_word;
  logic         accept, is_mc, illegal_b, mc_data, mc_rx, cur_mc;
  logic         overrun_ev, msgerr_ev, stop_wr, busy_any, rd_clr;
  logic [4:0]   mc;
  logic [15:0]  data_addr;

  assign mc       = cmd_word.wc;
  assign is_mc    = cmd_word.sa == rt_pkg::SA_MODE_LO ||
                    cmd_word.sa == rt_pkg::SA_MODE_HI;
  assign accept   = cmd_valid && !parity_bad &&
                    cmd_word.rt_addr == my_addr;
  assign illegal_b = !rev_a && (mc == rt_pkg::MC_DYN_BUS ||
                     (mc >= rt_pkg::MC_RSV1_LO && mc <= rt_pkg::MC_RSV1_HI) ||
                     mc >= rt_pkg::MC_RSV2_LO);
  assign mc_data  = mc >= rt_pkg::MC_DATA_LO && mc < rt_pkg::MC_RSV2_LO;
  assign mc_rx    = mc == rt_pkg::MC_SYNC_DATA || mc == rt_pkg::MC_SEL_SHUT ||
                    mc == rt_pkg::MC_OVR_SEL_SHUT;
  assign busy_any = dma_busy || job_valid;
  assign stop_wr  = reg_wr && reg_addr == rt_pkg::REG_STOP_TEST;
  assign rd_clr   = reg_rd && reg_addr == rt_pkg::REG_OPSTAT;
  // Held command is a mode code, so its low field is a code, not a count
  assign cur_mc   = cmd.sa == rt_pkg::SA_MODE_LO ||
                    cmd.sa == rt_pkg::SA_MODE_HI;
  // Mode data words sit in a 16-word table, ordinary data per subaddress
  assign data_addr = cur_mc ? mc_ptr + {12'h000, cmd.wc[3:0]} :
                     data_base + {6'h00, cmd.sa, count[4:0]};

  always_comb begin
    operational_status_reg = 16'h0000;
    operational_status_reg[rt_pkg::OPS_TEST_BIT]    = test_act;
    operational_status_reg[rt_pkg::OPS_OVERRUN_BIT] = ovr_flag;
    operational_status_reg[rt_pkg::OPS_MSGERR_BIT]  = err_flag;
    operational_status_reg[rt_pkg::OPS_SHUT_A_BIT]  = !chan_tx_enable[0];
    operational_status_reg[rt_pkg::OPS_SHUT_B_BIT]  = !chan_tx_enable[1];
    operational_status_reg[rt_pkg::OPS_INHIBIT_BIT] = inhibit;
    operational_status_reg[rt_pkg::OPS_PARITY_BIT]  = par_flag;
  end

  always_comb begin
    next_st = st;  next_cmd = cmd;  next_total = total;  next_count = count;
    next_tx_dir = tx_dir;  next_msg_err = msg_err;  next_buf_full = buf_full;
    next_tx_word = tx_word;  next_last_cmd = last_cmd;  next_shut = shut;
    next_sel_off = sel_off;  next_inhibit = inhibit;
    next_job_valid = 1'b0;  next_job = job;  next_timer_start = 1'b0;
    next_status_start = 1'b0;  next_status_word = status_word;
    overrun_ev = 1'b0;  msgerr_ev = 1'b0;
    case (st)
      M_RX: begin
        if (rx_word_valid) begin
          if (busy_any) begin
            overrun_ev = 1'b1;
          end else begin
            next_job_valid = 1'b1;
            next_job   = '{addr: data_addr, data: rx_word, write: 1'b1};
            next_count = count + 6'h01;
            if (cur_mc && cmd.wc == rt_pkg::MC_SEL_SHUT) begin
              next_sel_off[rx_word[0]] = 1'b1;
            end else if (cur_mc && cmd.wc == rt_pkg::MC_OVR_SEL_SHUT) begin
              next_sel_off[rx_word[0]] = 1'b0;
            end
            if (count + 6'h01 == total) begin
              next_st = M_RESP;
              next_timer_start = 1'b1;
            end
          end
        end
      end
      M_RESP: begin
        if (rx_word_valid && !tx_dir && !rev_a) begin
          msgerr_ev = 1'b1;
        end else if (fire) begin
          next_status_start = 1'b1;
          next_status_word = '{rt_addr: my_addr,
                               msg_err: msg_err || ill_s,
                               term_flag: term_fault_in && !inhibit};
          next_st = (tx_dir && total != 6'h00) ? M_TX : M_IDLE;
        end
      end
      M_TX: begin
        if (tx_word_done) begin
          if (!buf_full) begin
            overrun_ev = 1'b1;
          end else begin
            next_buf_full = 1'b0;
            next_count = count + 6'h01;
            if (count + 6'h01 == total) next_st = M_IDLE;
          end
        end
      end
      default: ;
    endcase
    // Prefetch while waiting to respond, then refill per word
    if (((st == M_RESP && tx_dir) || st == M_TX) && !buf_full &&
        !busy_any && !dma_done && count != total) begin
      next_job_valid = 1'b1;
      next_job = '{addr: data_addr, data: 16'h0000, write: 1'b0};
    end
    if (dma_done && !job.write) begin
      next_buf_full = 1'b1;
      next_tx_word  = dma_rd_word;
    end
    if (overrun_ev || msgerr_ev) begin
      next_st = M_IDLE;
      next_buf_full = 1'b0;
    end
    if (accept) begin
      next_cmd = cmd_word;
      next_count = 6'h00;
      next_msg_err = is_mc && illegal_b;
      next_buf_full = 1'b0;
      next_tx_dir = is_mc ? !mc_rx : cmd_word.tx;
      next_total = is_mc ? ((mc_data && !illegal_b) ? 6'h01 : 6'h00) :
                   (cmd_word.wc == 5'h00 ? rt_pkg::WC_FULL :
                    {1'b0, cmd_word.wc});
      if (is_mc && mc == rt_pkg::MC_LAST_CMD) begin
        next_last_cmd = cmd_word;
      end else begin
        next_job_valid = 1'b1;
        next_job = '{addr: cmd_ptr, data: cmd_word, write: 1'b1};
      end
      if (is_mc) begin
        case (mc)
          rt_pkg::MC_TX_SHUT:      next_shut[!cmd_chan] = 1'b1;
          rt_pkg::MC_OVR_TX_SHUT:  next_shut[!cmd_chan] = 1'b0;
          rt_pkg::MC_INH_FLAG:     next_inhibit = 1'b1;
          rt_pkg::MC_OVR_INH_FLAG: next_inhibit = 1'b0;
          default: ;
        endcase
      end
      if (!next_tx_dir && next_total != 6'h00) begin
        next_st = M_RX;
      end else begin
        next_st = M_RESP;
        next_timer_start = 1'b1;
      end
    end
  end

  // A pending request is dropped on any of the four terminating events
  assign abort = accept || overrun_ev || msgerr_ev || stop_wr;

  always_comb begin
    next_data_base = data_base;
    next_cmd_ptr   = cmd_ptr;
    next_mc_ptr    = mc_ptr;
    next_test_act  = test_act;
    next_reg_rdata = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        rt_pkg::REG_CTRL:
          if (reg_wdata[rt_pkg::CTRL_TEST_BIT]) next_test_act = 1'b1;
        rt_pkg::REG_STOP_TEST: next_test_act = 1'b0;
        rt_pkg::REG_DATA_BASE: next_data_base = reg_wdata;
        rt_pkg::REG_CMD_PTR:   next_cmd_ptr = reg_wdata;
        rt_pkg::REG_MC_PTR:    next_mc_ptr = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        rt_pkg::REG_OPSTAT:    next_reg_rdata = operational_status_reg;
        rt_pkg::REG_DATA_BASE: next_reg_rdata = data_base;
        rt_pkg::REG_CMD_PTR:   next_reg_rdata = cmd_ptr;
        rt_pkg::REG_MC_PTR:    next_reg_rdata = mc_ptr;
        rt_pkg::REG_LAST_CMD:  next_reg_rdata = last_cmd;
        default:               next_reg_rdata = 16'h0000;
      endcase
    end
    // Sticky flags: a new event in the read cycle survives the clear
    next_ovr_flag = (ovr_flag && !rd_clr) || overrun_ev;
    next_err_flag = (err_flag && !rd_clr) || msgerr_ev || overrun_ev;
    next_par_flag = (par_flag && !rd_clr) || parity_bad;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= M_IDLE;  cmd <= '0;  total <= 6'h00;  count <= 6'h00;
      tx_dir <= 1'b0;  msg_err <= 1'b0;  buf_full <= 1'b0;
      tx_word <= 16'h0000;  tx_word_valid <= 1'b0;  last_cmd <= 16'h0000;
      shut <= 2'b00;  sel_off <= 2'b00;  inhibit <= 1'b0;
      chan_tx_enable <= 2'b11;  job_valid <= 1'b0;  job <= '0;
      timer_start <= 1'b0;  status_start <= 1'b0;  status_word <= '0;
      test_act <= 1'b0;  ovr_flag <= 1'b0;  err_flag <= 1'b0;
      par_flag <= 1'b0;  addr_parity_fault_flag <= 1'b0;
      data_base <= 16'h0000;  cmd_ptr <= 16'h0000;  mc_ptr <= 16'h0000;
      reg_rdata <= 16'h0000;
    end else begin
      st <= next_st;  cmd <= next_cmd;  total <= next_total;
      count <= next_count;  tx_dir <= next_tx_dir;  msg_err <= next_msg_err;
      buf_full <= next_buf_full;  tx_word <= next_tx_word;
      tx_word_valid <= next_buf_full;  last_cmd <= next_last_cmd;
      shut <= next_shut;  sel_off <= next_sel_off;  inhibit <= next_inhibit;
      chan_tx_enable <= ~(next_shut | next_sel_off);
      job_valid <= next_job_valid;  job <= next_job;
      timer_start <= next_timer_start;  status_start <= next_status_start;
      status_word <= next_status_word;  test_act <= next_test_act;
      ovr_flag <= next_ovr_flag;  err_flag <= next_err_flag;
      par_flag <= next_par_flag;  addr_parity_fault_flag <= parity_bad;
      data_base <= next_data_base;  cmd_ptr <= next_cmd_ptr;
      mc_ptr <= next_mc_ptr;  reg_rdata <= next_reg_rdata;
    end
  end
endmodule

/* File: verilog/rt_pkg.sv */
package rt_pkg;
  // Response windows in hundredths of the printed unit (microseconds)
  localparam int CLK_NS          = 10;
  localparam int RESP_A_MIN_X100 = 425;
  localparam int RESP_A_MAX_X100 = 575;
  localparam int RESP_B_MIN_X100 = 925;
  localparam int RESP_B_MAX_X100 = 1000;
  localparam int RESP_A_MIN_CYC  = (RESP_A_MIN_X100 * 10 + CLK_NS - 1) / CLK_NS;
  localparam int RESP_A_MAX_CYC  = (RESP_A_MAX_X100 * 10) / CLK_NS;
  localparam int RESP_B_MIN_CYC  = (RESP_B_MIN_X100 * 10 + CLK_NS - 1) / CLK_NS;
  localparam int RESP_B_MAX_CYC  = (RESP_B_MAX_X100 * 10) / CLK_NS;
  // Aim at the middle of each window
  localparam int RESP_A_CYC = (RESP_A_MIN_CYC + RESP_A_MAX_CYC) / 2;
  localparam int RESP_B_CYC = (RESP_B_MIN_CYC + RESP_B_MAX_CYC) / 2;
  localparam int ADDR_SETTLE_CYC = 2;
  localparam int STROBE_CYC      = 4;

  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_OPSTAT    = 8'h04;
  localparam logic [7:0] REG_STOP_TEST = 8'h08;
  localparam logic [7:0] REG_DATA_BASE = 8'h0c;
  localparam logic [7:0] REG_CMD_PTR   = 8'h10;
  localparam logic [7:0] REG_MC_PTR    = 8'h14;
  localparam logic [7:0] REG_LAST_CMD  = 8'h18;

  localparam int OPS_TEST_BIT    = 0;
  localparam int OPS_OVERRUN_BIT = 1;
  localparam int OPS_MSGERR_BIT  = 2;
  localparam int OPS_SHUT_A_BIT  = 3;
  localparam int OPS_SHUT_B_BIT  = 4;
  localparam int OPS_INHIBIT_BIT = 5;
  localparam int OPS_PARITY_BIT  = 12;
  localparam int CTRL_TEST_BIT   = 0;

  localparam logic [4:0] SA_MODE_LO      = 5'h00;
  localparam logic [4:0] SA_MODE_HI      = 5'h1f;
  localparam logic [4:0] MC_DYN_BUS      = 5'h00;
  localparam logic [4:0] MC_TX_SHUT      = 5'h04;
  localparam logic [4:0] MC_OVR_TX_SHUT  = 5'h05;
  localparam logic [4:0] MC_INH_FLAG     = 5'h06;
  localparam logic [4:0] MC_OVR_INH_FLAG = 5'h07;
  localparam logic [4:0] MC_RSV1_LO      = 5'h09;
  localparam logic [4:0] MC_RSV1_HI      = 5'h0f;
  localparam logic [4:0] MC_DATA_LO      = 5'h10;
  localparam logic [4:0] MC_SYNC_DATA    = 5'h11;
  localparam logic [4:0] MC_LAST_CMD     = 5'h12;
  localparam logic [4:0] MC_SEL_SHUT     = 5'h14;
  localparam logic [4:0] MC_OVR_SEL_SHUT = 5'h15;
  localparam logic [4:0] MC_RSV2_LO      = 5'h16;
  localparam logic [5:0] WC_FULL         = 6'h20;

  typedef struct packed {
    logic [4:0] rt_addr;
    logic       tx;
    logic [4:0] sa;
    logic [4:0] wc;
  } cmd_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic        write;
  } dma_job_s;

  typedef struct packed {
    logic [4:0] rt_addr;
    logic       msg_err;
    logic       term_flag;
  } status_s;
endpackage

/* File: verilog/resp_timer.sv */
module resp_timer #(
  parameter int LAT_CYC = 0
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic start,
  input  wire logic rev_a,
  output logic      fire
);
  localparam logic [15:0] LOAD_A = 16'(rt_pkg::RESP_A_CYC - LAT_CYC);
  localparam logic [15:0] LOAD_B = 16'(rt_pkg::RESP_B_CYC - LAT_CYC);

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_fire;

  always_comb begin
    next_cnt  = cnt;
    next_fire = 1'b0;
    if (start) begin
      next_cnt = rev_a ? LOAD_A : LOAD_B;
    end else if (cnt != 16'h0000) begin
      next_cnt  = cnt - 16'h0001;
      next_fire = (cnt == 16'h0001);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= 16'h0000;
      fire <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      fire <= next_fire;
    end
  end
endmodule

/* File: verilog/dma_seq.sv */
module dma_seq (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             job_valid,
  input  wire rt_pkg::dma_job_s job,
  input  wire logic             abort,
  input  wire logic             gnt,
  input  wire logic             permit,
  input  wire logic [15:0]      mem_rdata,
  output logic                  busy,
  output logic                  done,
  output logic [15:0]           rd_word,
  output logic                  dma_req,
  output logic [15:0]           mem_addr,
  output logic                  mem_addr_oe,
  output logic [15:0]           mem_wdata,
  output logic                  mem_data_oe,
  output logic                  addr_valid_strobe,
  output logic                  mem_read_strobe,
  output logic                  mem_write_strobe
);
  typedef enum logic [2:0] {S_IDLE, S_REQ, S_ADDR, S_STROBE} seq_e;

  seq_e        st, next_st;
  logic [2:0]  cnt, next_cnt;
  logic [15:0] rd_meta, rd_sync;
  rt_pkg::dma_job_s cur, next_cur;
  logic        next_done;
  logic [15:0] next_rd_word;

  always_comb begin
    next_st      = st;
    next_cnt     = cnt;
    next_cur     = cur;
    next_done    = 1'b0;
    next_rd_word = rd_word;
    case (st)
      S_IDLE: begin
        if (job_valid) begin
          next_cur = job;
          next_st  = S_REQ;
        end
      end
      S_REQ: begin
        if (abort) begin
          next_st = S_IDLE;
        end else if (gnt && permit) begin
          next_st  = S_ADDR;
          next_cnt = 3'(rt_pkg::ADDR_SETTLE_CYC);
        end
      end
      S_ADDR: begin
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          next_st  = S_STROBE;
          next_cnt = 3'(rt_pkg::STROBE_CYC);
        end
      end
      S_STROBE: begin
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          // Strobe drop ends the access; read data sampled here
          next_st      = S_IDLE;
          next_done    = 1'b1;
          next_rd_word = rd_sync;
        end
      end
      default: next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st                <= S_IDLE;
      cnt               <= 3'h0;
      cur               <= '0;
      done              <= 1'b0;
      rd_word           <= 16'h0000;
      rd_meta           <= 16'h0000;
      rd_sync           <= 16'h0000;
      busy              <= 1'b0;
      dma_req           <= 1'b0;
      mem_addr          <= 16'h0000;
      mem_addr_oe       <= 1'b0;
      mem_wdata         <= 16'h0000;
      mem_data_oe       <= 1'b0;
      addr_valid_strobe <= 1'b0;
      mem_read_strobe   <= 1'b0;
      mem_write_strobe  <= 1'b0;
    end else begin
      st                <= next_st;
      cnt               <= next_cnt;
      cur               <= next_cur;
      done              <= next_done;
      rd_word           <= next_rd_word;
      rd_meta           <= mem_rdata;
      rd_sync           <= rd_meta;
      busy              <= next_st != S_IDLE;
      dma_req           <= next_st == S_REQ;
      mem_addr          <= next_cur.addr;
      mem_addr_oe       <= next_st == S_ADDR || next_st == S_STROBE;
      mem_wdata         <= next_cur.data;
      mem_data_oe       <= next_st == S_STROBE && next_cur.write;
      addr_valid_strobe <= next_st == S_STROBE;
      mem_read_strobe   <= next_st == S_STROBE && !next_cur.write;
      mem_write_strobe  <= next_st == S_STROBE && next_cur.write;
    end
  end
endmodule

/* File: tb/rt_mode_dma_props.sv */
module rt_mode_dma_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dma_gnt,
  input wire logic dma_req,
  input wire logic status_start,
  input wire logic mem_addr_oe,
  input wire logic addr_valid_strobe,
  input wire logic mem_read_strobe,
  input wire logic mem_write_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_strobe_in_av: assert property (
    mem_read_strobe || mem_write_strobe |-> addr_valid_strobe && mem_addr_oe)
    else $error("strobe outside address valid");
  a_one_strobe: assert property (
    !(mem_read_strobe && mem_write_strobe)) else $error("both strobes");
  a_av_after_addr: assert property (
    $rose(addr_valid_strobe) |-> $past(mem_addr_oe, 2))
    else $error("address valid before settle");
  a_oe_after_grant: assert property (
    $rose(mem_addr_oe) |-> $past(dma_gnt, 3)) else $error("drive without grant");
  a_read_length: assert property (
    $rose(mem_read_strobe) |-> mem_read_strobe [*4] ##1 !mem_read_strobe)
    else $error("read strobe length");
  a_write_length: assert property (
    $rose(mem_write_strobe) |-> mem_write_strobe [*4] ##1 !mem_write_strobe)
    else $error("write strobe length");
  a_req_drop_after: assert property (
    $fell(addr_valid_strobe) |-> !dma_req) else $error("request kept");
  a_status_pulse: assert property (
    status_start |=> !status_start) else $error("status pulse too long");
endmodule
bind rt_mode_dma rt_mode_dma_props u_props (.clk(clk), .rstn(rstn),
  .dma_gnt(dma_gnt), .dma_req(dma_req), .status_start(status_start),
  .mem_addr_oe(mem_addr_oe), .addr_valid_strobe(addr_valid_strobe),
  .mem_read_strobe(mem_read_strobe), .mem_write_strobe(mem_write_strobe));

/* File: tb/mem_host_model.sv */
module mem_host_model (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   slow,
  input  wire logic   dma_req,
  input  wire logic   mem_read_strobe,
  output logic        dma_gnt,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] age;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      age     <= 4'h0;
      dma_gnt <= 1'b0;
    end else begin
      age     <= dma_req ? age + 4'h1 : 4'h0;
      // Slow arbitration still lands well before any word completes
      dma_gnt <= dma_req && (dma_gnt || age >= (slow ? 4'h6 : 4'h1));
    end
  end
  // Released bus shows the inverse so a stale sample is caught
  assign mem_rdata = mem_read_strobe ? 16'h5a3c : 16'ha5c3;
endmodule

/* File: tb/tb_rt_mode_dma.sv */
module tb_rt_mode_dma;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clk, rstn, rev, ill, pen, par, cv, ch, slow, wr, rd;
  logic            req, gnt, st, rs, pf, tf;
  logic [1:0]      ten;
  logic [7:0]      ra;
  logic [7:0]      ers = 8'h8f;
  logic [15:0]     wd, rdat, mrd, v, tw;
  logic [39:0]     mcs = {5'h00,5'h01,5'h02,5'h08,5'h09,5'h0f,5'h16,5'h1f};
  rt_pkg::cmd_s    cw;
  rt_pkg::status_s sw;
  int              num_errors, check_count, rd_cyc, n;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  rt_mode_dma u_dut (.clk(clk), .rstn(rstn), .protocol_rev_select(rev),
    .illegal_command_in(ill), .term_addr_pins(5'h05), .term_addr_parity_in(par),
    .addr_parity_check_en(pen), .term_fault_in(tf), .cmd_valid(cv),
    .cmd_word(cw), .cmd_chan(ch), .rx_word_valid(1'b0), .rx_word(16'h0000),
    .tx_word_done(1'b0), .dma_gnt(gnt), .dma_permit(1'b1), .mem_rdata(mrd),
    .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .status_start(st), .status_word(sw), .tx_word_valid(), .tx_word(tw),
    .chan_tx_enable(ten), .addr_parity_fault_flag(pf), .dma_req(req),
    .mem_addr(), .mem_addr_oe(), .mem_wdata(), .mem_data_oe(),
    .addr_valid_strobe(), .mem_read_strobe(rs), .mem_write_strobe());
  mem_host_model u_host (.clk(clk), .rstn(rstn), .slow(slow), .dma_req(req),
    .mem_read_strobe(rs), .dma_gnt(gnt), .mem_rdata(mrd));
  always @(posedge clk) rd_cyc <= rd_cyc + int'(rs === 1'b1);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    {wr, ra, wd} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    {rd, ra} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
    @(posedge clk);
  endtask
  // Counts edges to the status pulse; 1200 means no answer at all
  task automatic cmd(input logic [4:0] mc, input logic err, input logic resp);
    int lo, hi;
    lo = rev ? rt_pkg::RESP_A_MIN_CYC : rt_pkg::RESP_B_MIN_CYC;
    hi = rev ? rt_pkg::RESP_A_MAX_CYC : rt_pkg::RESP_B_MAX_CYC;
    {cv, cw} <= {1'b1, 5'h05, 1'b1, 5'h1f, mc};
    @(posedge clk);
    cv <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (st !== 1'b1 && n < 1200);
    @(posedge clk);
    chk(resp ? (n >= lo && n <= hi) : (n == 1200), 1'b1);
    if (resp) chk(sw.msg_err, err);
  endtask
  task automatic finish_test();
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rstn, rev, ill, cv, ch, slow, wr, rd, cw, ra, wd, tf} = '0;
    {pen, par} = 2'b11;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    reg_wr(rt_pkg::REG_MC_PTR, 16'h0120);
    reg_rd(rt_pkg::REG_MC_PTR);
    chk(v, 16'h0120);
    reg_rd(8'h1c);
    chk(v, 16'h0000);
    for (int i = 0; i < 8; i++)
      cmd(mcs[5*i +: 5], ers[i], 1'b1);
    {ill, ch} <= 2'b11;
    cmd(5'h04, 1'b1, 1'b1);
    chk(ten, 2'b10);
    cmd(5'h05, 1'b1, 1'b1);
    chk(ten, 2'b11);
    {ill, ch, tf} <= 3'b001;
    cmd(5'h06, 1'b0, 1'b1);
    chk(sw.term_flag, 1'b0);
    cmd(5'h07, 1'b0, 1'b1);
    chk(sw.term_flag, 1'b1);
    cmd(5'h10, 1'b0, 1'b1);
    chk(rd_cyc, 4);
    chk(tw, 16'h5a3c);
    slow <= 1'b1;
    cmd(5'h13, 1'b0, 1'b1);
    chk(rd_cyc, 8);
    cmd(5'h12, 1'b0, 1'b1);
    reg_rd(rt_pkg::REG_LAST_CMD);
    chk(v, 16'h2ff2);
    par <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(5'h01, 1'b0, 1'b0);
    chk(pf, 1'b1);
    reg_rd(rt_pkg::REG_OPSTAT);
    chk(v[12], 1'b1);
    par <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(5'h01, 1'b0, 1'b1);
    rev <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(5'h00, 1'b0, 1'b1);
    cmd(5'h0a, 1'b0, 1'b1);
    finish_test();
  end
  initial begin
    #400us;
    num_errors++;
    finish_test();
  end
endmodule
